/* File: crc8_acc.sv */
// Running CRC-8 over bytes of one bus transaction.
// Assumes init and feed never come in the same cycle.
`timescale 1ns/1ns
`include "i2c_guard_regs.svh"
module crc8_acc (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic init_i,
   input wire logic feed_i,
   input wire logic [7:0] byte_i,
   output logic [7:0] crc_o
);
   import i2c_guard_pkg::*;

   crc_state_t s_reg;
   crc_state_t s_next;

   // MSB first, no final inversion
   function automatic logic [7:0] crc_step(input logic [7:0] c,
                                           input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ({x[6:0], 1'b0} ^ `CRC_POLY) : {x[6:0], 1'b0};
      end
      return x;
   endfunction : crc_step

   // Init restarts the checksum
   always_comb begin
      s_next = s_reg;
      if (init_i) begin
         s_next.crc = `CRC_INIT;
      end else if (feed_i) begin
         s_next.crc = crc_step(s_reg.crc, byte_i);
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_reg.crc <= `CRC_INIT;
      end else begin
         s_reg <= s_next;
      end
   end

   assign crc_o = s_reg.crc;

endmodule : crc8_acc

/* File: i2c_guard_pkg.sv */
// Types shared by the guarded I2C configuration port.
// Assumes the constants header is compiled alongside.
package i2c_guard_pkg;

   // Bus state machine
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TACK
   } i2c_st_t;

   // Register write strobe towards the register file
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } wr_req_t;

   // Fuse settings
   typedef struct packed {
      logic [2:0] addr_sel;
      logic crc_en;
      logic secure_en;
   } fuse_cfg_t;

   typedef struct packed {
      logic [7:0] crc;
   } crc_state_t;

   typedef struct packed {
      logic [15:0] lfsr;
   } lfsr_state_t;

   // Whole state of the slave
   typedef struct packed {
      i2c_st_t st;
      logic scl_q;
      logic sda_q;
      logic [7:0] sh;
      logic [3:0] bitcnt;
      logic [1:0] idx;
      logic rnw;
      logic nack;
      logic ack_drv;
      logic [7:0] tx;
      logic [7:0] reg_addr;
      logic [7:0] data;
      logic have_data;
      logic have_crc;
      logic crc_ok;
      logic pend;
      logic [7:0] pend_addr;
      logic [7:0] pend_data;
      logic [7:0] chal;
      logic [7:0] reply;
      logic [17:0] tmo;
      logic fault;
      wr_req_t wr;
   } slave_state_t;

endpackage : i2c_guard_pkg

/* File: i2c_guard_regs.svh */
// Constants of the guarded I2C configuration port: addresses, offsets,
// field positions, CRC and timing figures.
// Assumes inclusion by bare name from every file that needs them.
`ifndef I2C_GUARD_REGS_SVH
`define I2C_GUARD_REGS_SVH

// Slave addresses
`define BASE_ADDR 7'h08
`define CFG_ADDR 7'h08

// Register offsets of the guarded registers and of the challenge and reply registers
`define OFS_ST_OV 8'h10
`define OFS_ST_UV 8'h11
`define OFS_ST_RUN 8'h12
`define OFS_CTRL1 8'h20
`define OFS_VMON_EN 8'h21
`define OFS_CHAL 8'h30
`define OFS_REPLY 8'h31

// Field positions and masks
`define RUN_BIT 0
`define VMON_MASK 8'h0f

// Bit counting
`define BYTE_BITS 4'd8

// CRC-8 figures
`define CRC_POLY 8'h1d
`define CRC_INIT 8'hff

// Challenge generator
`define LFSR_SEED 16'hace1
`define LFSR_TAPS 16'hb400

// Guarded write timeout and clock rate
`define GUARD_TMO_MS 10
`define CLK_HZ 25000000

`endif

/* File: i2c_guard_slave.sv */
// I2C configuration slave with optional transaction CRC and guarded
// (challenge-response) writes to safety-critical registers.
// Assumes SCL/SDA are already synchronous to ref_clk_i and that the
// register file outside applies wr_o and serves rd_addr_o.
`timescale 1ns/1ns
`include "i2c_guard_regs.svh"
module i2c_guard_slave #(
   parameter int unsigned TMO_CYCLES = `GUARD_TMO_MS * (`CLK_HZ / 1000)
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input i2c_guard_pkg::fuse_cfg_t fuse_i,
   input wire logic config_mode_pin_i,
   input wire logic power_up_event_i,
   input wire logic ctrl1_secure_i,
   input wire logic crc_irq_mask_i,
   input wire logic crc_fault_clear_i,
   output logic [7:0] rd_addr_o,
   input wire logic [7:0] rd_data_i,
   output i2c_guard_pkg::wr_req_t wr_o,
   output logic crc_fault_o,
   output logic guard_pending_o,
   output logic irq_out_n_o
);
   import i2c_guard_pkg::*;

   slave_state_t s_reg;
   slave_state_t s_next;
   logic rise, fall, start, stop, load;
   logic crc_on, sec_on, prog_mode;
   logic [6:0] my_addr;
   logic [7:0] crc_val, rnd, tx_byte, crc_byte;
   logic crc_init, crc_feed;
   logic commit_bad, guard_go, reply_ok, reply_bad;

   // Safety-critical writes; every control write carries the reset-kind
   // bit, so all control writes go through the challenge
   function automatic logic is_guarded(input logic [7:0] a,
                                       input logic [7:0] d);
      logic g;
      g = 1'b0;
      if (a == `OFS_ST_OV || a == `OFS_ST_UV) begin
         g = |d;
      end else if (a == `OFS_ST_RUN) begin
         g = d[`RUN_BIT];
      end else if (a == `OFS_CTRL1) begin
         g = 1'b1;
      end else if (a == `OFS_VMON_EN) begin
         g = |(~d & `VMON_MASK);
      end
      return g;
   endfunction : is_guarded

   // Challenge and reply live here, the rest outside
   function automatic logic [7:0] rd_pick(input slave_state_t s,
                                          input logic [7:0] ext);
      if (s.reg_addr == `OFS_CHAL) begin
         return s.chal;
      end else if (s.reg_addr == `OFS_REPLY) begin
         return s.reply;
      end
      return ext;
   endfunction : rd_pick

   crc8_acc u_crc (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .init_i(crc_init),
      .feed_i(crc_feed),
      .byte_i(crc_byte),
      .crc_o(crc_val)
   );

   rand_gen u_rand (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .rnd_o(rnd)
   );

   // Mode selection from fuses and the config-mode pin
   assign prog_mode = config_mode_pin_i & ~power_up_event_i;
   assign crc_on = fuse_i.crc_en & ~prog_mode;
   assign sec_on = fuse_i.secure_en & ctrl1_secure_i & ~prog_mode;
   assign my_addr = config_mode_pin_i ? `CFG_ADDR
                  : (`BASE_ADDR | {4'h0, fuse_i.addr_sel});

   // Edge detection at the system clock; high speed needs a system
   // clock well above the bus rate, else edges are missed
   assign rise = scl_i & ~s_reg.scl_q;
   assign fall = ~scl_i & s_reg.scl_q;
   assign start = s_reg.scl_q & scl_i & s_reg.sda_q & ~sda_i;
   assign stop = s_reg.scl_q & scl_i & ~s_reg.sda_q & sda_i;

   // Next-state logic of the whole slave
   always_comb begin
      s_next = s_reg;
      crc_init = 1'b0;
      crc_feed = 1'b0;
      crc_byte = s_reg.sh;
      commit_bad = 1'b0;
      guard_go = 1'b0;
      reply_ok = 1'b0;
      reply_bad = 1'b0;
      load = 1'b0;
      tx_byte = rd_pick(s_reg, rd_data_i);
      s_next.scl_q = scl_i;
      s_next.sda_q = sda_i;
      s_next.wr.valid = 1'b0;

      // Pending guarded write expires
      if (s_reg.pend) begin
         if (s_reg.tmo == 18'(TMO_CYCLES - 1)) begin
            s_next.pend = 1'b0;
            s_next.chal = '0;
            s_next.reply = '0;
            s_next.tmo = '0;
         end else begin
            s_next.tmo = s_reg.tmo + 18'h1;
         end
      end

      // Software clear first so a new fault in the same cycle wins
      if (crc_fault_clear_i) begin
         s_next.fault = 1'b0;
      end

      // Commit a complete write at stop or repeated start
      if ((start || stop) && s_reg.have_data) begin
         if (crc_on && !(s_reg.have_crc && s_reg.crc_ok)) begin
            commit_bad = 1'b1;
            s_next.fault = 1'b1;
         end else if (s_reg.pend && s_reg.reg_addr == `OFS_REPLY) begin
            if (s_reg.data == s_reg.chal) begin
               reply_ok = 1'b1;
               s_next.wr = '{1'b1, s_reg.pend_addr, s_reg.pend_data};
            end else begin
               reply_bad = 1'b1;
            end
            s_next.pend = 1'b0;
            s_next.chal = '0;
            s_next.reply = '0;
            s_next.tmo = '0;
         end else if (sec_on && is_guarded(s_reg.reg_addr, s_reg.data)) begin
            guard_go = 1'b1;
            s_next.pend = 1'b1;
            s_next.pend_addr = s_reg.reg_addr;
            s_next.pend_data = s_reg.data;
            s_next.chal = rnd;
            s_next.reply = '0;
            s_next.tmo = '0;
         end else begin
            s_next.pend = 1'b0;
            s_next.chal = '0;
            s_next.reply = '0;
            s_next.tmo = '0;
            // Challenge and reply are never stored through the bus
            if (!(s_reg.reg_addr inside {`OFS_CHAL, `OFS_REPLY})) begin
               s_next.wr = '{1'b1, s_reg.reg_addr, s_reg.data};
            end
         end
      end

      if (start) begin
         // Any partial byte is simply dropped here
         s_next.st = ST_ADDR;
         s_next.bitcnt = '0;
         s_next.idx = '0;
         s_next.have_data = 1'b0;
         s_next.have_crc = 1'b0;
         s_next.ack_drv = 1'b0;
         crc_init = 1'b1;
      end else if (stop) begin
         s_next.st = ST_IDLE;
         s_next.ack_drv = 1'b0;
         s_next.have_data = 1'b0;
      end else begin
         unique case (s_reg.st)
            ST_IDLE: begin
            end
            ST_ADDR, ST_RX: begin
               if (rise) begin
                  s_next.sh = {s_reg.sh[6:0], sda_i};
                  s_next.bitcnt = s_reg.bitcnt + 4'h1;
               end else if (fall && s_reg.bitcnt == `BYTE_BITS) begin
                  // Only a whole byte is taken and acknowledged
                  s_next.bitcnt = '0;
                  if (s_reg.st == ST_ADDR) begin
                     if (s_reg.sh[7:1] == my_addr) begin
                        s_next.ack_drv = 1'b1;
                        s_next.rnw = s_reg.sh[0];
                        s_next.st = ST_ACK;
                        crc_feed = 1'b1;
                     end else begin
                        s_next.st = ST_IDLE;
                     end
                  end else begin
                     s_next.ack_drv = 1'b1;
                     s_next.st = ST_ACK;
                     if (s_reg.idx == 2'd0) begin
                        s_next.reg_addr = s_reg.sh;
                        crc_feed = 1'b1;
                     end else if (s_reg.idx == 2'd1) begin
                        s_next.data = s_reg.sh;
                        s_next.have_data = 1'b1;
                        crc_feed = 1'b1;
                     end else if (s_reg.idx == 2'd2) begin
                        s_next.have_crc = 1'b1;
                        s_next.crc_ok = (crc_val == s_reg.sh);
                     end
                     if (s_reg.idx != 2'd3) begin
                        s_next.idx = s_reg.idx + 2'd1;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (fall) begin
                  s_next.ack_drv = 1'b0;
                  if (s_reg.rnw) begin
                     load = 1'b1;
                  end else begin
                     s_next.st = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (fall) begin
                  if (s_reg.bitcnt == `BYTE_BITS) begin
                     s_next.ack_drv = 1'b0;
                     s_next.st = ST_TACK;
                  end else begin
                     s_next.ack_drv = ~s_reg.tx[7];
                     s_next.tx = {s_reg.tx[6:0], 1'b0};
                     s_next.bitcnt = s_reg.bitcnt + 4'h1;
                  end
               end
            end
            ST_TACK: begin
               if (rise) begin
                  s_next.nack = sda_i;
               end else if (fall) begin
                  if (s_reg.nack) begin
                     s_next.st = ST_IDLE;
                  end else begin
                     load = 1'b1;
                  end
               end
            end
            default: begin
               s_next.st = ST_IDLE;
            end
         endcase
      end

      // Load a read byte and drive its first bit; CRC follows the data
      if (load) begin
         if (crc_on && s_reg.idx == 2'd1) begin
            tx_byte = crc_val;
            s_next.idx = 2'd2;
         end else begin
            crc_byte = tx_byte;
            crc_feed = 1'b1;
            s_next.idx = 2'd1;
         end
         s_next.ack_drv = ~tx_byte[7];
         s_next.tx = {tx_byte[6:0], 1'b0};
         s_next.bitcnt = 4'h1;
         s_next.st = ST_TX;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Open-drain SDA: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_o = s_reg.ack_drv;
   assign rd_addr_o = s_reg.reg_addr;
   assign wr_o = s_reg.wr;
   assign crc_fault_o = s_reg.fault;
   assign guard_pending_o = s_reg.pend;
   assign irq_out_n_o = ~(s_reg.fault & ~crc_irq_mask_i);

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   a_ack_full_byte: assert property (
      s_reg.st inside {ST_ADDR, ST_RX} && fall
      && s_reg.bitcnt != `BYTE_BITS |=> !sda_oe_o)
      else $error("ack driven on an incomplete byte");
   a_partial_no_write: assert property (
      s_reg.st == ST_RX && !s_reg.have_data && (start || stop)
      |=> !wr_o.valid)
      else $error("write issued without a complete data byte");
   a_crc_bad_drop: assert property (
      commit_bad |=> crc_fault_o && !wr_o.valid ##1 !wr_o.valid)
      else $error("crc mismatch did not drop and flag");
   a_irq_from_flag: assert property (
      $rose(crc_fault_o) && !crc_irq_mask_i |-> !irq_out_n_o)
      else $error("interrupt not driven by crc fault");
   a_guard_hold: assert property (
      guard_go |=> guard_pending_o && !wr_o.valid
      && s_reg.chal == $past(rnd))
      else $error("guarded write not held with challenge");
   a_reply_apply: assert property (
      reply_ok |=> wr_o.valid && wr_o.addr == $past(s_reg.pend_addr)
      && s_reg.chal == '0 && s_reg.reply == '0)
      else $error("matching reply did not apply pending write");
   a_reply_drop: assert property (
      reply_bad |=> !wr_o.valid && !guard_pending_o && s_reg.chal == '0)
      else $error("mismatching reply did not drop pending write");
   a_guard_tmo: assert property (
      s_reg.pend && s_reg.tmo == 18'(TMO_CYCLES - 1) && !start && !stop
      |=> !guard_pending_o)
      else $error("pending guarded write did not time out");
   a_cfg_addr: assert property (
      config_mode_pin_i && s_reg.st == ST_ADDR && fall
      && s_reg.bitcnt == `BYTE_BITS && s_reg.sh[7:1] != `CFG_ADDR
      |=> !sda_oe_o)
      else $error("config mode answered a foreign address");

endmodule : i2c_guard_slave

/* File: i2c_host_model.sv */
// Bus master model for the configuration slave: open-drain SCL and SDA.
// Assumes the bench resolves SDA with the pull-up and feeds it back.
`timescale 1ns/1ns
module i2c_host_model (
   input wire logic ref_clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   int half = 4; // Half bus period in clocks; raised for a slow master
   logic crc_on = 1'b0;
   logic crc_bad = 1'b0;
   int rd_bytes = 1; // Bytes per read; with CRC on the second is the CRC
   logic [7:0] rd_last;

   // Released lines float high through the pull-ups
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : tick

   // MSB first, no final inversion
   function automatic logic [7:0] crc_byte(input logic [7:0] c,
      input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ({x[6:0], 1'b0} ^ 8'h1d) : {x[6:0], 1'b0};
      end
      return x;
   endfunction : crc_byte

   // Data moves one clock after SCL falls, so it never looks like START
   task automatic bit_x(input logic b, output logic r);
      sda_o = b;
      tick(half);
      scl_o = 1'b1;
      tick(half);
      r = sda_i;
      scl_o = 1'b0;
      tick(1);
   endtask : bit_x

   task automatic start_c();
      sda_o = 1'b1;
      tick(half);
      scl_o = 1'b1;
      tick(half);
      sda_o = 1'b0;
      tick(half);
      scl_o = 1'b0;
      tick(1);
   endtask : start_c

   task automatic stop_c();
      sda_o = 1'b0;
      tick(half);
      scl_o = 1'b1;
      tick(half);
      sda_o = 1'b1;
      tick(half);
   endtask : stop_c

   // Write transfer; last byte may be cut short; returns the ACK mask
   task automatic send(input logic [7:0] q[$], input int last_bits,
      output logic [7:0] acks);
      logic [7:0] c;
      logic r;
      int nb;
      c = 8'hff;
      acks = 8'h00;
      if (crc_on) begin
         foreach (q[k]) c = crc_byte(c, q[k]);
         q.push_back(crc_bad ? ~c : c);
      end
      start_c();
      foreach (q[k]) begin
         nb = (k == q.size() - 1) ? last_bits : 8;
         for (int i = 7; i > 7 - nb; i--) bit_x(q[k][i], r);
         if (nb == 8) begin
            bit_x(1'b1, r);
            acks[k] = ~r;
         end
      end
      stop_c();
   endtask : send

   // Read of rd_bytes bytes; ACK on all but the last, which gets NACK
   task automatic recv(input logic [6:0] a, output logic [7:0] d,
      output logic ack);
      logic [7:0] ab;
      logic [7:0] rb;
      logic r;
      ab = {a, 1'b1};
      start_c();
      for (int i = 7; i >= 0; i--) bit_x(ab[i], r);
      bit_x(1'b1, r);
      ack = ~r;
      for (int j = 0; j < rd_bytes; j++) begin
         for (int i = 7; i >= 0; i--) bit_x(1'b1, rb[i]);
         if (j == 0) d = rb;
         else rd_last = rb;
         bit_x(j == rd_bytes - 1, r);
      end
      stop_c();
   endtask : recv
endmodule : i2c_host_model

/* File: rand_gen.sv */
// Free-running pseudo-random source for the challenge byte.
// Assumes the byte is sampled at an unpredictable moment by the slave.
`timescale 1ns/1ns
`include "i2c_guard_regs.svh"
module rand_gen (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   output logic [7:0] rnd_o
);
   import i2c_guard_pkg::*;

   lfsr_state_t s_reg;
   lfsr_state_t s_next;

   // Galois shift; never reaches all-zero from a nonzero seed
   always_comb begin
      s_next.lfsr = {1'b0, s_reg.lfsr[15:1]};
      if (s_reg.lfsr[0]) begin
         s_next.lfsr = s_next.lfsr ^ `LFSR_TAPS;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_reg.lfsr <= `LFSR_SEED;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rnd_o = s_reg.lfsr[7:0];

endmodule : rand_gen

/* File: testbench.sv */
// Self-checking bench for the guarded configuration slave.
// Assumes the host model and the design files are compiled before it.
`timescale 1ns/1ns
module testbench;
   import i2c_guard_pkg::*;
   localparam int unsigned TMO = 3000; // Short guard timeout for the run
   logic ref_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   fuse_cfg_t fuse = '0;
   logic cfg_pin = 1'b0;
   logic pwr_up = 1'b0;
   logic sec_bit = 1'b1;
   logic mask = 1'b0;
   logic clr = 1'b0;
   logic [7:0] rd_data = 8'h00;
   logic scl, host_sda, sda_oe, sda_val, sda_line, fault, pend, irq_n;
   logic [7:0] rd_addr, acks, d, ch;
   logic ak;
   wr_req_t wr;
   wr_req_t exp_q[$];
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   logic [7:0] gr[5] = '{8'h10, 8'h11, 8'h12, 8'h20, 8'h21};
   logic [7:0] gd[5] = '{8'h80, 8'h02, 8'h01, 8'h00, 8'h0e};

   // Open-drain SDA with pull-up
   assign sda_line = host_sda & ~(sda_oe & ~sda_val);

   initial begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   i2c_host_model u_host (.ref_clk_i(ref_clk_i), .sda_i(sda_line),
      .scl_o(scl), .sda_o(host_sda));

   i2c_guard_slave #(.TMO_CYCLES(TMO)) u_dut (.ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_val),
      .sda_oe_o(sda_oe), .fuse_i(fuse), .config_mode_pin_i(cfg_pin),
      .power_up_event_i(pwr_up), .ctrl1_secure_i(sec_bit),
      .crc_irq_mask_i(mask), .crc_fault_clear_i(clr), .rd_addr_o(rd_addr),
      .rd_data_i(rd_data), .wr_o(wr), .crc_fault_o(fault),
      .guard_pending_o(pend), .irq_out_n_o(irq_n));

   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : tick

   task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic chk_wr(input wr_req_t exp, input wr_req_t got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] write expected %h seen %h", exp, got);
      end
   endtask : chk_wr

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   // Write transfer; the expected strobe is noted before it can appear
   task automatic wtx(input logic [6:0] a, input logic [7:0] r, dd, ea,
      input bit ew);
      if (ew) exp_q.push_back('{1'b1, r, dd});
      u_host.send('{{a, 1'b0}, r, dd}, 8, acks);
      chk("ack mask", ea, acks);
      tick(4);
   endtask : wtx

   // Pointer-only write, then a read of u_host.rd_bytes bytes
   task automatic rtx(input logic [6:0] a, input logic [7:0] r,
      output logic [7:0] v);
      u_host.send('{{a, 1'b0}, r}, 8, acks);
      chk("ack mask", 8'h03, acks);
      chk("pointer", r, rd_addr);
      u_host.recv(a, v, ak);
      chk("read ack", 8'h01, {7'h0, ak});
      tick(4);
   endtask : rtx

   // Each write strobe is matched against the oldest note
   always @(posedge ref_clk_i) begin
      if (arst_n_i === 1'b1 && wr.valid !== 1'b0) begin
         chk("write noted", 8'h01, {7'h0, exp_q.size() != 0});
         if (exp_q.size() != 0) chk_wr(exp_q.pop_front(), wr);
      end
   end

   // Hang guard, well above the expected run length
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         close_out();
      end
   end

   initial begin
      void'($urandom(30008));
      repeat (20) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      arst_n_i = 1'b1;
      tick(4);
      // Every fuse address code, and a neighbour that must be ignored
      for (int k = 0; k < 8; k++) begin
         fuse.addr_sel = 3'(k);
         d = 8'($urandom);
         wtx(7'h08 + 7'(k), 8'h40, d, 8'h07, 1'b1);
         wtx(7'h08 + 7'(k ^ 1), 8'h40, d, 8'h00, 1'b0);
      end
      rd_data = 8'($urandom);
      rtx(7'h0f, 8'h40, d);
      chk("read data", rd_data, d);
      fuse.addr_sel = 3'h0;
      // Seven-bit data byte, then a slow master
      u_host.send('{8'h10, 8'h40, 8'h5a}, 7, acks);
      chk("ack mask", 8'h03, acks);
      u_host.half = 12;
      wtx(7'h08, 8'h42, 8'($urandom), 8'h07, 1'b1);
      u_host.half = 4;
      // CRC on: good, corrupted, masked, cleared
      fuse.crc_en = 1'b1;
      u_host.crc_on = 1'b1;
      wtx(7'h08, 8'h41, 8'($urandom), 8'h0f, 1'b1);
      chk("fault", 8'h00, {7'h0, fault});
      u_host.crc_bad = 1'b1;
      wtx(7'h08, 8'h41, 8'h33, 8'h0f, 1'b0);
      chk("fault", 8'h01, {7'h0, fault});
      chk("irq", 8'h00, {7'h0, irq_n});
      mask = 1'b1;
      tick(2);
      chk("irq", 8'h01, {7'h0, irq_n});
      mask = 1'b0;
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      tick(2);
      chk("fault", 8'h00, {7'h0, fault});
      u_host.crc_bad = 1'b0;
      u_host.crc_on = 1'b0;
      // Read with CRC on: data, then CRC over address byte and data
      u_host.rd_bytes = 2;
      rd_data = 8'($urandom);
      rtx(7'h08, 8'h40, d);
      chk("read data", rd_data, d);
      ch = u_host.crc_byte(u_host.crc_byte(8'hff, 8'h11), rd_data);
      chk("read crc", ch, u_host.rd_last);
      u_host.rd_bytes = 1;
      // Config mode: fixed address, CRC and guarding off
      fuse = '{3'h5, 1'b1, 1'b1};
      cfg_pin = 1'b1;
      wtx(7'h08, 8'h12, 8'h01, 8'h07, 1'b1);
      wtx(7'h0d, 8'h40, 8'h00, 8'h00, 1'b0);
      pwr_up = 1'b1;
      wtx(7'h08, 8'h40, 8'h11, 8'h07, 1'b0);
      chk("fault", 8'h01, {7'h0, fault});
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      cfg_pin = 1'b0;
      pwr_up = 1'b0;
      fuse = '{3'h0, 1'b0, 1'b1};
      // Each guarded kind waits, then another write cancels it
      for (int k = 0; k < 5; k++) begin
         wtx(7'h08, gr[k], gd[k], 8'h07, 1'b0);
         chk("pending", 8'h01, {7'h0, pend});
         wtx(7'h08, 8'h40, gd[k], 8'h07, 1'b1);
         chk("pending", 8'h00, {7'h0, pend});
      end
      wtx(7'h08, 8'h12, 8'h00, 8'h07, 1'b1);
      wtx(7'h08, 8'h21, 8'h0f, 8'h07, 1'b1);
      fuse.secure_en = 1'b0;
      wtx(7'h08, 8'h20, 8'h00, 8'h07, 1'b1);
      fuse.secure_en = 1'b1;
      // Runtime enable bit off: control writes go straight through
      sec_bit = 1'b0;
      wtx(7'h08, 8'h20, 8'h00, 8'h07, 1'b1);
      sec_bit = 1'b1;
      // Matching reply applies the held write
      wtx(7'h08, 8'h12, 8'h01, 8'h07, 1'b0);
      rtx(7'h08, 8'h30, ch);
      chk("pending", 8'h01, {7'h0, pend});
      exp_q.push_back('{1'b1, 8'h12, 8'h01});
      wtx(7'h08, 8'h31, ch, 8'h07, 1'b0);
      chk("pending", 8'h00, {7'h0, pend});
      rtx(7'h08, 8'h30, d);
      chk("challenge", 8'h00, d);
      rtx(7'h08, 8'h31, d);
      chk("reply", 8'h00, d);
      // Wrong reply drops the held write
      wtx(7'h08, 8'h20, 8'h00, 8'h07, 1'b0);
      rtx(7'h08, 8'h30, ch);
      wtx(7'h08, 8'h31, ~ch, 8'h07, 1'b0);
      chk("pending", 8'h00, {7'h0, pend});
      rtx(7'h08, 8'h30, d);
      chk("challenge", 8'h00, d);
      // No reply: the held write expires after the timeout
      wtx(7'h08, 8'h11, 8'h01, 8'h07, 1'b0);
      tick(TMO - 100);
      chk("pending", 8'h01, {7'h0, pend});
      tick(200);
      chk("pending", 8'h00, {7'h0, pend});
      chk("writes left", 8'h00, 8'(exp_q.size()));
      close_out();
   end
endmodule : testbench
